// ==== hdl/ccs_regs.sv ====
// capture control and configuration slot register group
// Function
// - free-run bit 0 starts/stops streaming in fixed format 0 or scalable format
// - single-frame bit 0 sends one frame in fixed format 0 or scalable format, then clears itself when sent
// - burst bit 1 and burst count bits 16-31 never affect transmission
// - store bit 0 copies working configuration into the selected slot when it is 1 to 3
// - store command bit returns to zero by itself
// - writing slot 0 to 3 to load register copies slot into working set
// - load register read returns the slot most recently loaded
// - format register holds 3-bit code in bits 0-2, reset to 7
module ccs_regs
  import ccs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire ccs_req_s req,
  output logic [DATA_W-1:0] rdData,
  output logic rdValid,
  input wire logic frameSent,
  output logic streamEn,
  output logic shotStart,
  output logic shotBusy,
  output ccs_cfg_s workCfg
);

  ccs_cfg_s work_r;
  ccs_cfg_s slot_r [NUM_SLOTS];
  logic freeRun_r;
  logic shot_r;
  logic shotStart_r;
  logic burstBit_r;
  logic [COUNT_W-1:0] burstCount_r;
  logic [SLOT_W-1:0] storeSlot_r;
  logic [LOAD_W-1:0] lastLoad_r;
  logic [DATA_W-1:0] rdData_r;
  logic rdValid_r;
  logic fmtOk;
  logic wrFormat;
  logic wrFreeRun;
  logic wrStore;
  logic wrSingle;
  logic wrStoreSlot;
  logic wrLoad;
  logic storeOk;
  logic loadOk;
  logic [DATA_W-1:0] rdMux;

  // write strobes per register
  assign wrFormat = req.wr && (req.addr == OFF_FORMAT);
  assign wrFreeRun = req.wr && (req.addr == OFF_FREE_RUN);
  assign wrStore = req.wr && (req.addr == OFF_STORE_CMD);
  assign wrSingle = req.wr && (req.addr == OFF_SINGLE);
  assign wrStoreSlot = req.wr && (req.addr == OFF_STORE_SLOT);
  assign wrLoad = req.wr && (req.addr == OFF_LOAD_SLOT);

  // only fixed format 0 and the scalable format may transmit
  assign fmtOk = (work_r.fmt == FMT_FIXED0) || (work_r.fmt == FMT_SCALABLE);

  // slot checks: load compares the whole write word so upper garbage is rejected; store sees only the kept low nibble
  assign storeOk = wrStore && req.wdata[STORE_BIT]
                   && (storeSlot_r >= SLOT_FIRST_USER)
                   && (storeSlot_r <= SLOT_LAST);
  assign loadOk = wrLoad && (req.wdata <= DATA_W'(SLOT_LAST));

  // working configuration: format writes and slot loads
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      work_r.fmt <= FMT_RESET;
    end
    else if (loadOk)
    begin
      work_r <= slot_r[req.wdata[LOAD_W-1:0]];
    end
    else if (wrFormat)
    begin
      work_r.fmt <= req.wdata[FMT_LSB +: FMT_W];
    end
  end

  // user slots 1..3 are filled by store commands; slot 0 keeps the default set
  // because storeOk never names it, so every slot has one driver of one kind
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SLOTS; gi++)
    begin : g_slot
      always_ff @(posedge clk_sys)
      begin
        if (reset)
        begin
          slot_r[gi].fmt <= FMT_RESET;
        end
        else if (storeOk && (storeSlot_r == SLOT_W'(gi)))
        begin
          slot_r[gi] <= work_r;
        end
      end
    end
  endgenerate

  // last loaded slot, reported on read
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      lastLoad_r <= LOAD_SLOT_RESET;
    end
    else if (loadOk)
    begin
      lastLoad_r <= req.wdata[LOAD_W-1:0];
    end
  end

  // store slot select; only the low nibble is kept
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      storeSlot_r <= STORE_SLOT_RESET;
    end
    else if (wrStoreSlot)
    begin
      storeSlot_r <= req.wdata[SLOT_W-1:0];
    end
  end

  // free-run enable; streaming also drops while the format is unsuitable
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      freeRun_r <= 1'b0;
    end
    else if (wrFreeRun)
    begin
      freeRun_r <= req.wdata[RUN_BIT];
    end
  end

  assign streamEn = freeRun_r && fmtOk;

  // single frame: a request while busy is ignored, so a completion in the same cycle still clears the frame bit
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      shot_r <= 1'b0;
      shotStart_r <= 1'b0;
    end
    else
    begin
      shotStart_r <= 1'b0;
      if (wrSingle && req.wdata[SHOT_BIT] && fmtOk && !shot_r)
      begin
        shot_r <= 1'b1;
        shotStart_r <= 1'b1;
      end
      else if (shot_r && frameSent)
      begin
        shot_r <= 1'b0;
      end
    end
  end

  assign shotStart = shotStart_r;
  assign shotBusy = shot_r;

  // burst fields are stored for readback only and feed nothing
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      burstBit_r <= 1'b0;
      burstCount_r <= '0;
    end
    else if (wrSingle)
    begin
      burstBit_r <= req.wdata[BURST_BIT];
      burstCount_r <= req.wdata[COUNT_LSB +: COUNT_W];
    end
  end

  // read mux; unmapped offsets read as zero
  always_comb
  begin
    rdMux = '0;
    case (req.addr)
      OFF_FORMAT: rdMux[FMT_LSB +: FMT_W] = work_r.fmt;
      OFF_FREE_RUN: rdMux[RUN_BIT] = freeRun_r;
      OFF_STORE_CMD: rdMux = '0;
      OFF_SINGLE:
      begin
        rdMux[SHOT_BIT] = shot_r;
        rdMux[BURST_BIT] = burstBit_r;
        rdMux[COUNT_LSB +: COUNT_W] = burstCount_r;
      end
      OFF_STORE_SLOT: rdMux[SLOT_W-1:0] = storeSlot_r;
      OFF_LOAD_SLOT: rdMux[LOAD_W-1:0] = lastLoad_r;
      default: rdMux = '0;
    endcase
  end

  // registered read data, one cycle after the read strobe
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rdData_r <= '0;
      rdValid_r <= 1'b0;
    end
    else
    begin
      rdValid_r <= req.rd;
      if (req.rd)
      begin
        rdData_r <= rdMux;
      end
    end
  end

  assign rdData = rdData_r;
  assign rdValid = rdValid_r;
  assign workCfg = work_r;

endmodule

// ==== hdl/ccs_pkg.sv ====
// package for the capture and configuration slot control register group
package ccs_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  // register offsets from the camera base address
  localparam logic [11:0] OFF_FORMAT = 12'h608;
  localparam logic [11:0] OFF_FREE_RUN = 12'h614;
  localparam logic [11:0] OFF_STORE_CMD = 12'h618;
  localparam logic [11:0] OFF_SINGLE = 12'h61c;
  localparam logic [11:0] OFF_STORE_SLOT = 12'h620;
  localparam logic [11:0] OFF_LOAD_SLOT = 12'h624;
  // field positions
  localparam int FMT_LSB = 0;
  localparam int FMT_W = 3;
  localparam int RUN_BIT = 0;
  localparam int STORE_BIT = 0;
  localparam int SHOT_BIT = 0;
  localparam int BURST_BIT = 1;
  localparam int COUNT_LSB = 16;
  localparam int COUNT_W = 16;
  localparam int SLOT_W = 4;
  localparam int LOAD_W = 2;
  // format codes and reset values
  localparam logic [2:0] FMT_FIXED0 = 3'h0;
  localparam logic [2:0] FMT_SCALABLE = 3'h7;
  localparam logic [2:0] FMT_RESET = 3'h7;
  localparam logic [3:0] STORE_SLOT_RESET = 4'h1;
  localparam logic [1:0] LOAD_SLOT_RESET = 2'h0;
  localparam logic [3:0] SLOT_FIRST_USER = 4'h1;
  localparam logic [3:0] SLOT_LAST = 4'h3;
  localparam int NUM_SLOTS = 4;

  // register access request from the serial bus link layer
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ccs_req_s;

  // working configuration set as held in a memory slot
  typedef struct packed {
    logic [FMT_W-1:0] fmt;
  } ccs_cfg_s;
endpackage

// ==== verif/ccs_regs_properties.sv ====
// assertion checker for the capture and slot control registers
module ccs_regs_properties
  import ccs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire ccs_req_s req,
  input wire logic [DATA_W-1:0] rdData,
  input wire logic rdValid,
  input wire logic frameSent,
  input wire logic streamEn,
  input wire logic shotStart,
  input wire logic shotBusy,
  input wire ccs_cfg_s workCfg
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff reset;
  // only fixed format 0 and the scalable format may transmit
  logic fmtOk;
  logic wrShot;
  assign fmtOk = workCfg.fmt == FMT_FIXED0 || workCfg.fmt == FMT_SCALABLE;
  assign wrShot = req.wr && req.addr == OFF_SINGLE;
  property p_rd; req.rd |=> rdValid; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_gate; !fmtOk |-> !streamEn; endproperty
  a_gate: assert property (p_gate) else $error("stream in bad format");
  property p_run; req.wr && req.addr == OFF_FREE_RUN && req.wdata[0] ##1 fmtOk |-> streamEn;
  endproperty
  a_run: assert property (p_run) else $error("stream not started");
  property p_shot; wrShot && req.wdata[0] && fmtOk && !shotBusy |=> shotStart && shotBusy;
  endproperty
  a_shot: assert property (p_shot) else $error("frame not started");
  property p_cause; shotStart |-> $past(wrShot) && $past(req.wdata[0]); endproperty
  a_cause: assert property (p_cause) else $error("frame without request");
  property p_done; shotBusy && frameSent |=> !shotBusy; endproperty
  a_done: assert property (p_done) else $error("frame bit not cleared");
  property p_pulse; shotStart |=> !shotStart; endproperty
  a_pulse: assert property (p_pulse) else $error("frame start held too long");
  property p_fmt; req.wr && req.addr == OFF_FORMAT |=> workCfg.fmt == $past(req.wdata[2:0]);
  endproperty
  a_fmt: assert property (p_fmt) else $error("format not taken");
  property p_bad; req.wr && req.addr == OFF_LOAD_SLOT && req.wdata > 3 |=> $stable(workCfg);
  endproperty
  a_bad: assert property (p_bad) else $error("bad load acted");
endmodule

bind ccs_regs ccs_regs_properties u_ccs_regs_properties (.clk_sys(clk_sys), .reset(reset),
  .req(req), .rdData(rdData), .rdValid(rdValid), .frameSent(frameSent), .streamEn(streamEn),
  .shotStart(shotStart), .shotBusy(shotBusy), .workCfg(workCfg));

// ==== verif/tb_ccs_regs.sv ====
// self-checking bench for the capture and slot control registers
module tb_ccs_regs;
  timeunit 1ns;
  timeprecision 1ns;
  import ccs_pkg::*;
  logic clk_sys = 0;
  logic reset = 1;
  logic frameSent = 0;
  ccs_req_s req = '0;
  logic [31:0] rdData;
  logic rdValid, streamEn, shotStart, shotBusy;
  ccs_cfg_s workCfg;
  logic [31:0] expQ[$];
  logic [2:0] f[4];
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  always #25 clk_sys = ~clk_sys;
  ccs_regs u_ccs_regs (.clk_sys(clk_sys), .reset(reset), .req(req), .rdData(rdData),
    .rdValid(rdValid), .frameSent(frameSent), .streamEn(streamEn), .shotStart(shotStart),
    .shotBusy(shotBusy), .workCfg(workCfg));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task complete_run();
    // a read that was never answered is a mismatch too
    if (expQ.size() != 0)
    begin
      err_count++;
      $display("Error at %0t: %0d reads unanswered", $time, expQ.size());
    end
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // request held over one sampling edge, then dropped
  task op(input logic w, input logic r, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    req <= '{w, r, a, d};
    @(posedge clk_sys);
    req <= '0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    op(1'b1, 1'b0, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    expQ.push_back(e);
    op(1'b0, 1'b1, a, 32'h0);
  endtask
  // answers arrive in request order; the cycle cap stops a hang
  always @(negedge clk_sys)
  begin
    if (rdValid === 1'b1 && expQ.size() == 0)
    begin
      err_count++;
      $display("Error at %0t: read answer without request", $time);
    end
    else if (rdValid === 1'b1)
      chk(rdData, expQ.pop_front());
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      complete_run();
    end
  end
  initial
  begin
    void'($urandom(87053));
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    rd(OFF_FORMAT, 32'h7);
    rd(OFF_LOAD_SLOT, 32'h0);
    rd(12'h700, 32'h0);
    wr(OFF_FREE_RUN, $urandom() | 32'h1);
    @(negedge clk_sys);
    chk(streamEn, 32'h1);
    rd(OFF_FREE_RUN, 32'h1);
    wr(OFF_FORMAT, 32'h3);
    @(negedge clk_sys);
    chk(streamEn, 32'h0);
    wr(OFF_FORMAT, 32'h0);
    @(negedge clk_sys);
    chk(streamEn, 32'h1);
    $display("free run test done");
    // burst fields set too; they must not matter
    wr(OFF_SINGLE, 32'hffff0003);
    @(negedge clk_sys);
    chk({shotStart, shotBusy}, 32'h3);
    repeat (3) @(posedge clk_sys);
    frameSent <= 1'b1;
    @(posedge clk_sys);
    frameSent <= 1'b0;
    @(negedge clk_sys);
    chk(shotBusy, 32'h0);
    rd(OFF_SINGLE, 32'hffff0002);
    wr(OFF_FORMAT, 32'h4);
    wr(OFF_SINGLE, 32'h1);
    @(negedge clk_sys);
    chk(shotBusy, 32'h0);
    $display("single frame test done");
    for (int s = 1; s < 4; s++)
    begin
      f[s] = 3'($urandom_range(5));
      wr(OFF_FORMAT, {29'h0, f[s]});
      wr(OFF_STORE_SLOT, s);
      wr(OFF_STORE_CMD, 32'h1);
    end
    rd(OFF_STORE_CMD, 32'h0);
    // slot 5 must not alias onto a real slot
    wr(OFF_FORMAT, 32'h6);
    wr(OFF_STORE_SLOT, 32'h5);
    wr(OFF_STORE_CMD, 32'h1);
    f[0] = 3'h7;
    for (int s = 0; s < 4; s++)
    begin
      wr(OFF_LOAD_SLOT, s);
      @(negedge clk_sys);
      chk(workCfg, f[s]);
      rd(OFF_LOAD_SLOT, s);
    end
    wr(OFF_LOAD_SLOT, 32'h4);
    rd(OFF_LOAD_SLOT, 32'h3);
    @(negedge clk_sys);
    chk(workCfg, f[3]);
    $display("slot test done");
    // a second reset in mid-run must bring free-run, format, store slot and load slot back to their defaults
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys);
    chk(streamEn, 32'h0);
    rd(OFF_FORMAT, 32'h7);
    rd(OFF_STORE_SLOT, 32'h1);
    rd(OFF_LOAD_SLOT, 32'h0);
    $display("reset test done");
    repeat (3) @(posedge clk_sys);
    complete_run();
  end
endmodule
